// File: common/vta_pkg.sv
// package: register map, field layout and carriers for the vbus threshold/alarm registers
package vta_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses on the internal register port)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STOP_LOW = 8'h74; // discharge end level bits 7:0
    localparam logic [7:0] ADDR_STOP_HIGH = 8'h75; // discharge end level bits 9:8
    localparam logic [7:0] ADDR_OV_LOW = 8'h76; // over-voltage limit bits 7:0
    localparam logic [7:0] ADDR_OV_HIGH = 8'h77; // over-voltage limit bits 9:8
    localparam logic [7:0] ADDR_UV_LOW = 8'h78; // under-voltage limit bits 7:0
    localparam logic [7:0] ADDR_UV_HIGH = 8'h79; // under-voltage limit bits 9:8
    localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h90; // extra event flags

    // ------------------------------------------------------------
    // widths, reset values and field positions
    // ------------------------------------------------------------
    localparam int LIMIT_W = 10; // threshold and measurement width
    localparam int STEP_MV = 25; // one lsb of any threshold, in mV
    localparam int HIGH_W = 2; // bits of a threshold held in its high byte
    localparam int EV_W = 4; // number of event flags
    localparam logic [LIMIT_W-1:0] LIMIT_RESET = 10'h000; // threshold reset value
    localparam logic [7:0] BYTE_RESET = 8'h00; // reset / unmapped read value
    localparam logic [EV_W-1:0] EV_RESET = 4'h0; // event flag reset value

    // event flag index (internal vector) and bit position in the status byte
    localparam int EV_SWAP = 0; // quick swap received
    localparam int EV_TEMP = 1; // overtemp
    localparam int EV_CFG = 2; // config pin over-voltage
    localparam int EV_SLOW = 3; // slow oscillator timer expired
    localparam int BIT_SWAP = 0;
    localparam int BIT_TEMP = 2;
    localparam int BIT_CFG = 3;
    localparam int BIT_SLOW = 4;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr; // write strobe, one cycle
        logic rd; // read strobe, one cycle
        logic [7:0] addr; // register offset
        logic [7:0] wdata; // write data
    } vta_req_t;

    typedef struct packed {
        logic [LIMIT_W-1:0] value; // measured vbus, 25 mV units
        logic valid; // one-cycle pulse: new measurement
    } vta_meas_t;

endpackage

// File: verilog/vta_edge_sync.sv
// two-flop synchroniser with rising edge detect for asynchronous event levels
`timescale 1ns/1ps
module vta_edge_sync #(
    parameter int W = 4
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);

    // ------------------------------------------------------------
    // synchroniser stages
    // ------------------------------------------------------------
    logic [W-1:0] meta; // first stage, read only by level
    logic [W-1:0] prev; // delayed copy for edge detect
    logic [W-1:0] next_meta;
    logic [W-1:0] next_level;
    logic [W-1:0] next_prev;

    // next values: shift through the stages
    always_comb begin
        next_meta = async_in;
        next_level = meta;
        next_prev = level;
    end

    // registers, synchronous active-low reset
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            meta <= '0;
            level <= '0;
            prev <= '0;
        end else begin
            meta <= next_meta;
            level <= next_level;
            prev <= next_prev;
        end
    end

    // edge seen only from synchronised stages
    assign rise = level & ~prev;

endmodule // vta_edge_sync

// File: verilog/vta_regs.sv
// vbus discharge-end / alarm threshold registers, alarm compare and extra event flags
//
// Overview of operation
// - discharge end level: 10 bits, high byte 1:0
// - source stops discharge at level, else zero
// - over-voltage limit: 10 bits over two bytes
// - measurement above over limit sets alert
// - over limit of zero still compares
// - under-voltage limit: 10 bits over two bytes
// - measurement below under limit sets alert
// - status bit 4: slow timer expired
// - status bit 3: config pin over-voltage unattached
// - status bit 2: overtemp shutdown detected
// - status bit 0: quick swap received, enabled
// - reserved status bits read zero, ignore writes
// - flags clear by write-one or by read
// - flag interrupts only where mask bit set
`timescale 1ns/1ps
module vta_regs (
    input wire logic core_clk,
    input wire logic rstn,
    input vta_pkg::vta_req_t req,
    output logic [7:0] rdata,
    input vta_pkg::vta_meas_t meas,
    input wire logic voltage_alarm_inhibit,
    input wire logic clear_by_read,
    input wire logic quick_swap_receive_enable,
    input wire logic vbus_source_role,
    input wire logic discharge_active,
    input wire logic port_unattached,
    input wire logic slow_osc_timer_expired,
    input wire logic config_pin_overvoltage,
    input wire logic overtemp_detect,
    input wire logic quick_swap_signal,
    input wire logic [7:0] event_mask,
    output logic [vta_pkg::LIMIT_W-1:0] discharge_target,
    output logic discharge_halt,
    output logic over_voltage_alert_flag,
    output logic under_voltage_alert_flag,
    output logic [7:0] event_flags,
    output logic vendor_irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [vta_pkg::LIMIT_W-1:0] discharge_end_level; // stop level
    logic [vta_pkg::LIMIT_W-1:0] over_voltage_limit; // high alarm
    logic [vta_pkg::LIMIT_W-1:0] under_voltage_limit; // low alarm
    logic [vta_pkg::EV_W-1:0] status; // sticky event flags
    logic [vta_pkg::LIMIT_W-1:0] next_discharge_end_level;
    logic [vta_pkg::LIMIT_W-1:0] next_over_voltage_limit;
    logic [vta_pkg::LIMIT_W-1:0] next_under_voltage_limit;
    logic [vta_pkg::EV_W-1:0] next_status;
    logic [7:0] next_rdata;
    logic [vta_pkg::LIMIT_W-1:0] next_discharge_target;
    logic next_discharge_halt;
    logic next_ov_flag;
    logic next_uv_flag;
    logic [7:0] next_event_flags;
    logic next_vendor_irq;
    logic [7:0] status_byte; // status as seen on the bus
    logic [7:0] mask_byte_used; // mask bits where the flag is set
    logic [vta_pkg::EV_W-1:0] ev_rise; // synchronised rising edges
    logic [vta_pkg::EV_W-1:0] ev_set; // qualified set requests
    logic [vta_pkg::EV_W-1:0] ev_clr; // clear requests from software
    logic [vta_pkg::EV_W-1:0] wdata_flags; // write data at flag positions

    // ------------------------------------------------------------
    // event input synchronisers
    // ------------------------------------------------------------
    vta_edge_sync #(.W(vta_pkg::EV_W)) u_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .async_in({slow_osc_timer_expired, config_pin_overvoltage,
                   overtemp_detect, quick_swap_signal}),
        .level(),
        .rise(ev_rise)
    );

    // ------------------------------------------------------------
    // status byte packing
    // ------------------------------------------------------------
    // reserved bits 7:5 and 1 stay zero on read
    always_comb begin
        status_byte = vta_pkg::BYTE_RESET;
        status_byte[vta_pkg::BIT_SWAP] = status[vta_pkg::EV_SWAP];
        status_byte[vta_pkg::BIT_TEMP] = status[vta_pkg::EV_TEMP];
        status_byte[vta_pkg::BIT_CFG] = status[vta_pkg::EV_CFG];
        status_byte[vta_pkg::BIT_SLOW] = status[vta_pkg::EV_SLOW];
        wdata_flags[vta_pkg::EV_SWAP] = req.wdata[vta_pkg::BIT_SWAP];
        wdata_flags[vta_pkg::EV_TEMP] = req.wdata[vta_pkg::BIT_TEMP];
        wdata_flags[vta_pkg::EV_CFG] = req.wdata[vta_pkg::BIT_CFG];
        wdata_flags[vta_pkg::EV_SLOW] = req.wdata[vta_pkg::BIT_SLOW];
        mask_byte_used = event_mask & status_byte;
    end

    // ------------------------------------------------------------
    // next-state computation
    // ------------------------------------------------------------
    always_comb begin
        next_discharge_end_level = discharge_end_level;
        next_over_voltage_limit = over_voltage_limit;
        next_under_voltage_limit = under_voltage_limit;
        next_rdata = rdata;
        // register writes: each byte lands in its own slice
        if (req.wr) begin
            case (req.addr)
                vta_pkg::ADDR_STOP_LOW: next_discharge_end_level[7:0] = req.wdata;
                vta_pkg::ADDR_STOP_HIGH: begin
                    next_discharge_end_level[9:8] = req.wdata[1:0];
                end
                vta_pkg::ADDR_OV_LOW: next_over_voltage_limit[7:0] = req.wdata;
                vta_pkg::ADDR_OV_HIGH: next_over_voltage_limit[9:8] = req.wdata[1:0];
                vta_pkg::ADDR_UV_LOW: next_under_voltage_limit[7:0] = req.wdata;
                vta_pkg::ADDR_UV_HIGH: next_under_voltage_limit[9:8] = req.wdata[1:0];
                default: ; // flags handled below, others ignored
            endcase
        end
        // register reads: data held until the next read
        if (req.rd) begin
            case (req.addr)
                vta_pkg::ADDR_STOP_LOW: next_rdata = discharge_end_level[7:0];
                vta_pkg::ADDR_STOP_HIGH: next_rdata = {6'h00, discharge_end_level[9:8]};
                vta_pkg::ADDR_OV_LOW: next_rdata = over_voltage_limit[7:0];
                vta_pkg::ADDR_OV_HIGH: next_rdata = {6'h00, over_voltage_limit[9:8]};
                vta_pkg::ADDR_UV_LOW: next_rdata = under_voltage_limit[7:0];
                vta_pkg::ADDR_UV_HIGH: next_rdata = {6'h00, under_voltage_limit[9:8]};
                vta_pkg::ADDR_EVENT_FLAGS: next_rdata = status_byte;
                default: next_rdata = vta_pkg::BYTE_RESET; // unmapped
            endcase
        end
        // event qualification
        ev_set = vta_pkg::EV_RESET;
        ev_set[vta_pkg::EV_SLOW] = ev_rise[vta_pkg::EV_SLOW];
        ev_set[vta_pkg::EV_CFG] = ev_rise[vta_pkg::EV_CFG] & port_unattached;
        ev_set[vta_pkg::EV_TEMP] = ev_rise[vta_pkg::EV_TEMP];
        ev_set[vta_pkg::EV_SWAP] = ev_rise[vta_pkg::EV_SWAP] & quick_swap_receive_enable;
        // clear: write-one in mode 0, read of the status byte in mode 1
        ev_clr = vta_pkg::EV_RESET;
        if (!clear_by_read && req.wr && req.addr == vta_pkg::ADDR_EVENT_FLAGS) begin
            ev_clr = wdata_flags;
        end else if (clear_by_read && req.rd && req.addr == vta_pkg::ADDR_EVENT_FLAGS) begin
            ev_clr = status; // only what was returned is cleared
        end
        // a set in the same cycle wins over the clear
        next_status = (status & ~ev_clr) | ev_set;
        // alarm compare on each new measurement, same 25 mV units
        next_ov_flag = meas.valid && !voltage_alarm_inhibit
                       && (meas.value > over_voltage_limit);
        next_uv_flag = meas.valid && !voltage_alarm_inhibit
                       && (meas.value < under_voltage_limit);
        // source honours a nonzero stop level, otherwise safe zero
        next_discharge_target = vbus_source_role ? discharge_end_level : vta_pkg::LIMIT_RESET;
        next_discharge_halt = discharge_active && meas.valid
                              && (meas.value <= discharge_target);
        next_event_flags = status_byte;
        next_vendor_irq = |mask_byte_used;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            discharge_end_level <= vta_pkg::LIMIT_RESET;
            over_voltage_limit <= vta_pkg::LIMIT_RESET;
            under_voltage_limit <= vta_pkg::LIMIT_RESET;
            status <= vta_pkg::EV_RESET;
            rdata <= vta_pkg::BYTE_RESET;
            discharge_target <= vta_pkg::LIMIT_RESET;
            discharge_halt <= 1'b0;
            over_voltage_alert_flag <= 1'b0;
            under_voltage_alert_flag <= 1'b0;
            event_flags <= vta_pkg::BYTE_RESET;
            vendor_irq <= 1'b0;
        end else begin
            discharge_end_level <= next_discharge_end_level;
            over_voltage_limit <= next_over_voltage_limit;
            under_voltage_limit <= next_under_voltage_limit;
            status <= next_status;
            rdata <= next_rdata;
            discharge_target <= next_discharge_target;
            discharge_halt <= next_discharge_halt;
            over_voltage_alert_flag <= next_ov_flag;
            under_voltage_alert_flag <= next_uv_flag;
            event_flags <= next_event_flags;
            vendor_irq <= next_vendor_irq;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    ov_alarm_set_a: assert property (meas.valid && !voltage_alarm_inhibit
        && meas.value > over_voltage_limit |=> over_voltage_alert_flag)
        else $error("over-voltage alert not raised");
    ov_zero_limit_a: assert property (meas.valid && !voltage_alarm_inhibit
        && over_voltage_limit == 10'h000 && meas.value != 10'h000 |=> over_voltage_alert_flag)
        else $error("zero over limit disabled compare");
    alarm_inhibit_a: assert property (voltage_alarm_inhibit
        |=> !over_voltage_alert_flag && !under_voltage_alert_flag)
        else $error("alarm raised while inhibited");
    uv_alarm_set_a: assert property (meas.valid && !voltage_alarm_inhibit
        && meas.value < under_voltage_limit |=> under_voltage_alert_flag)
        else $error("under-voltage alert not raised");
    status_reserved_a: assert property (req.rd
        && req.addr == vta_pkg::ADDR_EVENT_FLAGS |=> rdata[7:5] == 3'h0 && rdata[1] == 1'b0)
        else $error("reserved status bits nonzero");
    stop_high_read_a: assert property (req.rd
        && req.addr == vta_pkg::ADDR_STOP_HIGH |=> rdata[7:2] == 6'h00)
        else $error("stop level high byte reserved bits nonzero");
    flag_set_wins_a: assert property (ev_set[vta_pkg::EV_SLOW]
        |=> status[vta_pkg::EV_SLOW] ##1 event_flags[vta_pkg::BIT_SLOW])
        else $error("slow timer flag lost");
    write_one_clear_a: assert property (!clear_by_read && req.wr
        && req.addr == vta_pkg::ADDR_EVENT_FLAGS && req.wdata[vta_pkg::BIT_CFG]
        && !ev_set[vta_pkg::EV_CFG] |=> !status[vta_pkg::EV_CFG])
        else $error("write-one did not clear flag");
    cfg_attached_a: assert property (port_unattached == 1'b0
        && !status[vta_pkg::EV_CFG] |=> !status[vta_pkg::EV_CFG])
        else $error("config fault set while attached");
    irq_mask_a: assert property (1'b1
        |=> vendor_irq == |($past(event_mask) & event_flags))
        else $error("interrupt does not follow masked flags");
    sink_target_a: assert property (!vbus_source_role |=> discharge_target == 10'h000)
        else $error("sink discharge target not zero");

    ov_alarm_c: cover property (over_voltage_alert_flag);
    read_clear_c: cover property (clear_by_read && req.rd
        && req.addr == vta_pkg::ADDR_EVENT_FLAGS && status != 4'h0);
    irq_c: cover property (vendor_irq);

endmodule // vta_regs

// File: sim/vta_host_model.sv
// host-side model of the port manager reaching the threshold registers
`timescale 1ns/1ps
module vta_host_model (
    input wire logic core_clk,
    output vta_pkg::vta_req_t req,
    input wire logic [7:0] rdata
);
    initial req = '0; // idle port at time zero

    // one-cycle write strobe, launched just after an edge
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        #1 req = '0;
    endtask

    // one-cycle read strobe; data stands from the edge after it
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk);
        #1 req = '0;
        @(posedge core_clk);
        #1 d = rdata;
    endtask
endmodule // vta_host_model

// File: sim/tb_top.sv
// self-checking bench for the vbus threshold and event flag registers
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
    logic core_clk, rstn, inhibit, clr_rd, swap_en, src_role, dis_act, unatt;
    logic [3:0] ev; // slow timer, config pin, overtemp, quick swap
    logic [7:0] mask, rdata, ev_flags, d;
    logic [9:0] target;
    logic halt, ov, uv, irq;
    logic [2:0] seen;
    int bad_count = 0;
    int n_checks = 0;
    vta_pkg::vta_req_t req;
    vta_pkg::vta_meas_t meas;

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk; // 25 MHz
    end

    vta_host_model host (.core_clk(core_clk), .req(req), .rdata(rdata));
    vta_regs uut (.core_clk(core_clk), .rstn(rstn), .req(req), .rdata(rdata), .meas(meas),
        .voltage_alarm_inhibit(inhibit), .clear_by_read(clr_rd),
        .quick_swap_receive_enable(swap_en), .vbus_source_role(src_role),
        .discharge_active(dis_act), .port_unattached(unatt), .slow_osc_timer_expired(ev[3]),
        .config_pin_overvoltage(ev[2]), .overtemp_detect(ev[1]), .quick_swap_signal(ev[0]),
        .event_mask(mask), .discharge_target(target), .discharge_halt(halt),
        .over_voltage_alert_flag(ov), .under_voltage_alert_flag(uv), .event_flags(ev_flags),
        .vendor_irq(irq));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // one measurement; collects halt/over/under pulses over the answer window
    task automatic measure(input logic [9:0] v, output logic [2:0] s);
        tick(1);
        meas = '{value: v, valid: 1'b1};
        tick(1);
        meas.valid = 1'b0;
        s = 3'b000;
        repeat (3) begin
            s = s | {halt, ov, uv};
            tick(1);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // watchdog: tests need well under 2000 cycles
    initial begin
        #400000;
        bad_count++;
        stop_test();
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        rstn = 1'b0; inhibit = 1'b0; clr_rd = 1'b0; swap_en = 1'b1; src_role = 1'b0;
        dis_act = 1'b0; unatt = 1'b1; ev = 4'h0; mask = 8'h00; meas = '0;
        tick(10);
        rstn = 1'b1;
        // reset values and an unmapped read
        for (int a = 8'h74; a <= 8'h79; a++) begin
            host.read_reg(a[7:0], d); `CHK(d, 8'h00)
        end
        host.read_reg(8'h90, d); `CHK(d, 8'h00)
        host.read_reg(8'h80, d); `CHK(d, 8'h00)
        $display("test reset_values done");
        // all ones: reserved bits read zero
        for (int a = 8'h74; a <= 8'h79; a++) host.write_reg(a[7:0], 8'hFF);
        host.write_reg(8'h90, 8'hFF);
        for (int a = 8'h74; a <= 8'h79; a++) begin
            host.read_reg(a[7:0], d); `CHK(d, a[0] ? 8'h03 : 8'hFF)
        end
        host.read_reg(8'h90, d); `CHK(d, 8'h00)
        $display("test access_kinds done");
        // limits above / below vbus as software keeps them
        host.write_reg(8'h76, 8'hA0); host.write_reg(8'h77, 8'h00);
        host.write_reg(8'h78, 8'h50); host.write_reg(8'h79, 8'h00);
        measure(10'h0C8, seen); `CHK(seen, 3'b010)
        measure(10'h0A0, seen); `CHK(seen, 3'b000)
        measure(10'h050, seen); `CHK(seen, 3'b000)
        measure(10'h04F, seen); `CHK(seen, 3'b001)
        inhibit = 1'b1;
        measure(10'h3FF, seen); `CHK(seen, 3'b000)
        measure(10'h000, seen); `CHK(seen, 3'b000)
        $display("test alarms done");
        // discharge end level as source, zero as sink
        host.write_reg(8'h74, 8'h23); host.write_reg(8'h75, 8'h01);
        src_role = 1'b1; dis_act = 1'b1;
        tick(3); `CHK(target, 10'h123)
        measure(10'h100, seen); `CHK(seen, 3'b100)
        measure(10'h200, seen); `CHK(seen, 3'b000)
        src_role = 1'b0;
        tick(3); `CHK(target, 10'h000)
        dis_act = 1'b0; inhibit = 1'b0;
        host.write_reg(8'h76, 8'h00);
        measure(10'h051, seen); `CHK(seen, 3'b010)
        $display("test discharge_zero_limit done");
        // event flags, masking and write-one clear
        ev = 4'hF;
        tick(6); `CHK(ev_flags, 8'h1D)
        `CHK(irq, 1'b0)
        mask = 8'h04;
        tick(2); `CHK(irq, 1'b1)
        ev = 4'h0;
        host.read_reg(8'h90, d); `CHK(d, 8'h1D)
        host.write_reg(8'h90, 8'h04);
        tick(3); `CHK(ev_flags, 8'h19)
        `CHK(irq, 1'b0)
        host.write_reg(8'h90, 8'h19);
        tick(3); `CHK(ev_flags, 8'h00)
        // gated events: swap disabled, port attached
        swap_en = 1'b0; unatt = 1'b0; ev = 4'h5;
        tick(6); `CHK(ev_flags, 8'h00)
        ev = 4'h0;
        tick(2);
        // clear on read
        clr_rd = 1'b1; ev = 4'h2;
        tick(6);
        host.read_reg(8'h90, d); `CHK(d, 8'h04)
        ev = 4'h0;
        tick(3); `CHK(ev_flags, 8'h00)
        $display("test event_flags done");
        // reset in mid-run returns programmed levels to zero
        rstn = 1'b0;
        tick(2);
        rstn = 1'b1;
        host.read_reg(8'h74, d); `CHK(d, 8'h00)
        host.read_reg(8'h78, d); `CHK(d, 8'h00)
        $display("test mid_reset done");
        stop_test();
    end
endmodule // tb_top
